/* hdl/uftr_regs.sv */
// Purpose: Enhanced feature, divisor, flow level and ready status registers
// Assumes: One channel's registers; FIFO levels arrive from the FIFO logic
// Notes:   Other channels' ready bits come in as plain inputs

`timescale 1ns/1ps

// Function
// (R1) Low four feature bits select software flow
// (R2) Feature bit 4 gates protected register bits
// (R3) Special character match flags identification bit 4
// (R4) Auto RTS high at halt, low at restore
// (R5) Auto CTS halts transmit while CTS high
// (R6) Divisor is high byte then low byte
// (R7) Divisor writes refused while sleep enabled
// (R8) Halt low nibble, restore high nibble, steps four
// (R9) Halt/restore writes need feature4 and modem6
// (R10) Software keeps halt above restore
// (R11) Software loads levels before enabling flow
// (R12) Trigger levels: transmit low, receive high
// (R13) Trigger writes need feature4 and modem6
// (R14) Zero nibble falls back to FIFO control level
// (R15) Software writes level divided by four
// (R16) Ready low bits: transmit spaces reach trigger
// (R17) Ready high bits: receive above trigger or timeout
// (R18) Ready status at 111 when enabled, no loopback
// (R19) Modem bit 6 set opens level access
// (R20) Nibbles compare as value times four
module uftr_regs
  import uftr_pkg::*;
#(
  parameter int LVL_W = 7
) (
  // Clock, reset and enable
  input  wire logic             mclk,
  input  wire logic             resetn,
  input  wire logic             ce,
  // Host register port
  input  wire uftr_bus_t        bus,
  output logic      [7:0]       rdata,
  output logic                  rdata_valid,
  // FIFO levels and events from this channel
  input  wire logic [LVL_W-1:0] rx_count,
  input  wire logic [LVL_W-1:0] tx_space,
  input  wire logic             rx_timeout,
  input  wire logic             rx_char_valid,
  input  wire logic [7:0]       rx_char,
  input  wire logic [7:0]       xoff2_char,
  input  wire logic [LVL_W-1:0] fcr_rx_level,
  input  wire logic [LVL_W-1:0] fcr_tx_level,
  input  wire logic             iir_read,
  // Ready bits of the other three channels
  input  wire logic [2:0]       other_tx_rdy,
  input  wire logic [2:0]       other_rx_rdy,
  // Flow control pins
  input  wire logic             cts_pin,
  output logic                  rts_out,
  output logic                  tx_halt,
  // Configuration and status outputs
  output logic      [3:0]       swfc_mode,
  output logic      [15:0]      baud_divisor,
  output logic                  special_flag,
  output logic                  tx_trig_rdy,
  output logic                  rx_trig_rdy
);

  // All state of the block but the CTS filter and reset sync lives in one struct; the reset
  // synchroniser is kept apart because it runs on the raw pin
  // reset and must not be frozen or cleared by its own output
  typedef struct packed {
    uftr_regs_t       r;
    logic [7:0]       rdata;
    logic             rdata_valid;
    logic             rts;
    logic             halt;
    logic             special;
    logic             tx_rdy;
    logic             rx_rdy;
  } uftr_st_t;

  uftr_st_t   st_reg;
  uftr_st_t   st_next;
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  logic       cts_lvl;
  logic       sel;
  logic       wr_en;
  logic       lvl_access;
  logic [LVL_W-1:0] halt_lvl;
  logic [LVL_W-1:0] restore_lvl;
  logic [LVL_W-1:0] tx_trig;
  logic [LVL_W-1:0] rx_trig;

  // Nibble to byte count, times four
  // Shift instead of multiply; zero stays zero for the fallback
  function automatic logic [LVL_W-1:0] nib_bytes(input logic [3:0] n);
    nib_bytes = LVL_W'({n, 2'b00}); // [R20]
  endfunction

  // Protected write: masked bits kept unless enhanced mode is on
  function automatic logic [7:0] prot_wr(input logic [7:0] old_v,
                                         input logic [7:0] new_v,
                                         input logic [7:0] mask,
                                         input logic       enh);
    prot_wr = enh ? new_v : ((old_v & mask) | (new_v & ~mask));
  endfunction

  // Reset release through two flops
  // Assertion is immediate, release waits two edges so that no
  // flop sees reset lift close to a clock edge; not gated by ce
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // CTS is a pin, so it is filtered before use
  // Costs four edges of latency; a glitch of one sample never
  // reaches the halt logic
  uftr_sync #(.W(1)) u_cts_sync (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .ce        (ce),
    .pin_in    (cts_pin),
    .level_out (cts_lvl)
  );

  // Decode and gating
  // Level access is a live AND of both bits, not a latch
  assign sel        = !bus.cs_n;
  assign wr_en      = sel && bus.wr;
  assign lvl_access = st_reg.r.enhanced_feature_ctrl[UFTR_EFR_ENH_BIT]
                   && st_reg.r.modem_control_reg[UFTR_MCR_LVL_ACCESS]; // [R9] [R13] [R19]

  // Effective levels, with FIFO control fallback on zero trigger nibble
  // Halt above restore is left to software; with a bad pair the
  // halt compare is tested first and wins
  always_comb begin
    halt_lvl    = nib_bytes(st_reg.r.flow_halt_restore_levels[3:0]); // [R8]
    restore_lvl = nib_bytes(st_reg.r.flow_halt_restore_levels[7:4]); // [R8]
    tx_trig     = (st_reg.r.fifo_trigger_levels[3:0] == 4'h0) ? fcr_tx_level
                : nib_bytes(st_reg.r.fifo_trigger_levels[3:0]); // [R12] [R14]
    rx_trig     = (st_reg.r.fifo_trigger_levels[7:4] == 4'h0) ? fcr_rx_level
                : nib_bytes(st_reg.r.fifo_trigger_levels[7:4]); // [R12] [R14]
  end

  // Next state: register writes, reads, flow control and status
  always_comb begin
    st_next             = st_reg;
    st_next.rdata_valid = 1'b0;

    // Register writes; a refused write leaves no trace at the
    // ports, so software must read back to see it landed
    if (wr_en) begin
      unique case (bus.page)
        UFTR_PAGE_DIVISOR: begin
          // Sleep mode locks the divisor
          if (!st_reg.r.interrupt_enable_reg[UFTR_IER_SLEEP]) begin // [R7]
            if (bus.addr == UFTR_ADDR_DIV_LOW) begin
              st_next.r.div_low = bus.wdata;
            end else if (bus.addr == UFTR_ADDR_DIV_HIGH) begin
              st_next.r.div_high = bus.wdata;
            end
          end
        end
        UFTR_PAGE_ENHANCED: begin
          if (bus.addr == UFTR_ADDR_EFR) begin
            st_next.r.enhanced_feature_ctrl = bus.wdata; // [R1]
          end
        end
        default: begin
          // Normal page; level registers overlay 6 and 7 when opened
          // Unused page code three lands here as well
          if (bus.addr == UFTR_ADDR_IER) begin
            st_next.r.interrupt_enable_reg = prot_wr(st_reg.r.interrupt_enable_reg, bus.wdata,
              UFTR_IER_ENH_MASK, st_reg.r.enhanced_feature_ctrl[UFTR_EFR_ENH_BIT]); // [R2]
          end else if (bus.addr == UFTR_ADDR_FCR) begin
            st_next.r.fifo_control_reg = prot_wr(st_reg.r.fifo_control_reg, bus.wdata,
              UFTR_FCR_ENH_MASK, st_reg.r.enhanced_feature_ctrl[UFTR_EFR_ENH_BIT]); // [R2]
          end else if (bus.addr == UFTR_ADDR_MCR) begin
            st_next.r.modem_control_reg = prot_wr(st_reg.r.modem_control_reg, bus.wdata,
              UFTR_MCR_ENH_MASK, st_reg.r.enhanced_feature_ctrl[UFTR_EFR_ENH_BIT]); // [R2]
          end else if (bus.addr == UFTR_ADDR_TCR && lvl_access) begin
            st_next.r.flow_halt_restore_levels = bus.wdata; // [R9]
          end else if (bus.addr == UFTR_ADDR_TLR && lvl_access) begin
            st_next.r.fifo_trigger_levels = bus.wdata; // [R13]
          end
        end
      endcase
    end

    // Register reads
    // Unmapped or locked addresses answer zero rather than stale
    // data, so a read never leaks a register that is closed
    if (sel && bus.rd) begin
      st_next.rdata_valid = 1'b1;
      st_next.rdata       = UFTR_RST_BYTE;
      unique case (bus.page)
        UFTR_PAGE_DIVISOR: begin
          if (bus.addr == UFTR_ADDR_DIV_LOW) begin
            st_next.rdata = st_reg.r.div_low;
          end else if (bus.addr == UFTR_ADDR_DIV_HIGH) begin
            st_next.rdata = st_reg.r.div_high;
          end
        end
        UFTR_PAGE_ENHANCED: begin
          if (bus.addr == UFTR_ADDR_EFR) begin
            st_next.rdata = st_reg.r.enhanced_feature_ctrl;
          end
        end
        default: begin
          if (bus.addr == UFTR_ADDR_IER) begin
            st_next.rdata = st_reg.r.interrupt_enable_reg;
          end else if (bus.addr == UFTR_ADDR_MCR) begin
            st_next.rdata = st_reg.r.modem_control_reg;
          end else if (bus.addr == UFTR_ADDR_TCR && lvl_access) begin
            st_next.rdata = st_reg.r.flow_halt_restore_levels;
          end else if (bus.addr == UFTR_ADDR_FIFO_RDY
                       && st_reg.r.modem_control_reg[UFTR_MCR_RDY_EN]
                       && !st_reg.r.modem_control_reg[UFTR_MCR_LOOPBACK]) begin
            // Ready status takes precedence over the trigger register
            st_next.rdata = {other_rx_rdy, st_reg.rx_rdy,
                             other_tx_rdy, st_reg.tx_rdy}; // [R18]
          end else if (bus.addr == UFTR_ADDR_TLR && lvl_access) begin
            st_next.rdata = st_reg.r.fifo_trigger_levels;
          end
        end
      endcase
    end

    // Auto RTS with hysteresis; hold between the two levels
    // The hold band keeps RTS from chattering as one character
    // enters and leaves the FIFO near a single threshold
    if (!st_reg.r.enhanced_feature_ctrl[UFTR_EFR_AUTO_RTS]) begin
      st_next.rts = 1'b0;
    end else if (rx_count >= halt_lvl) begin
      st_next.rts = 1'b1; // [R4]
    end else if (rx_count <= restore_lvl) begin
      st_next.rts = 1'b0; // [R4]
    end

    // Auto CTS halts the transmitter on a high level
    // Follows the filtered level, so halt lags the pin by five edges
    st_next.halt = st_reg.r.enhanced_feature_ctrl[UFTR_EFR_AUTO_CTS] && cts_lvl; // [R5]

    // Special character flag; a match wins over the clearing read
    // A read that clears in the same cycle as a new match would
    // otherwise lose the event
    if (st_reg.r.enhanced_feature_ctrl[UFTR_EFR_SPECIAL] && rx_char_valid
        && rx_char == xoff2_char) begin
      st_next.special = 1'b1; // [R3]
    end else if (iir_read) begin
      st_next.special = 1'b0;
    end

    // Ready status for this channel
    // Registered for clean outputs; status is one edge behind the
    // FIFO counts, which a host polling the bus never notices
    st_next.tx_rdy = tx_space >= tx_trig; // [R16]
    st_next.rx_rdy = (rx_count > rx_trig) || rx_timeout; // [R17]
  end

  // State register; reset sync is owned by its own process
  // Field by field so the reset value of the low divisor byte
  // can differ from the rest of the register file
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.r           <= '0;
      st_reg.r.div_low   <= UFTR_RST_DIV_LOW;
      st_reg.rdata       <= UFTR_RST_BYTE;
      st_reg.rdata_valid <= 1'b0;
      st_reg.rts         <= 1'b0;
      st_reg.halt        <= 1'b0;
      st_reg.special     <= 1'b0;
      st_reg.tx_rdy      <= 1'b0;
      st_reg.rx_rdy      <= 1'b0;
    end else if (ce) begin
      st_reg.r           <= st_next.r;
      st_reg.rdata       <= st_next.rdata;
      st_reg.rdata_valid <= st_next.rdata_valid;
      st_reg.rts         <= st_next.rts;
      st_reg.halt        <= st_next.halt;
      st_reg.special     <= st_next.special;
      st_reg.tx_rdy      <= st_next.tx_rdy;
      st_reg.rx_rdy      <= st_next.rx_rdy;
    end
  end

  // Outputs straight from flops
  // No logic between flop and port, so outputs never glitch
  assign rdata        = st_reg.rdata;
  assign rdata_valid  = st_reg.rdata_valid;
  assign rts_out      = st_reg.rts;
  assign tx_halt      = st_reg.halt;
  assign swfc_mode    = st_reg.r.enhanced_feature_ctrl[UFTR_EFR_SWFC_MSB:0]; // [R1]
  assign baud_divisor = {st_reg.r.div_high, st_reg.r.div_low}; // [R6]
  assign special_flag = st_reg.special;
  assign tx_trig_rdy  = st_reg.tx_rdy;
  assign rx_trig_rdy  = st_reg.rx_rdy;

endmodule

/* hdl/uftr_pkg.sv */
// Purpose: Shared constants and carrier types for the flow/threshold block
// Assumes: 8-bit host data bus, 3-bit address, four channels
// Notes:   Register page selection is modelled by a page select input

package uftr_pkg;

  // Register addresses within a channel (A[2:0])
  localparam logic [2:0] UFTR_ADDR_DIV_LOW   = 3'h0;
  localparam logic [2:0] UFTR_ADDR_IER       = 3'h1;
  localparam logic [2:0] UFTR_ADDR_DIV_HIGH  = 3'h1;
  localparam logic [2:0] UFTR_ADDR_FCR       = 3'h2;
  localparam logic [2:0] UFTR_ADDR_EFR       = 3'h2;
  localparam logic [2:0] UFTR_ADDR_MCR       = 3'h4;
  localparam logic [2:0] UFTR_ADDR_TCR       = 3'h6;
  localparam logic [2:0] UFTR_ADDR_TLR       = 3'h7;
  localparam logic [2:0] UFTR_ADDR_FIFO_RDY  = 3'h7;

  // Register page selects
  localparam logic [1:0] UFTR_PAGE_NORMAL    = 2'h0;
  localparam logic [1:0] UFTR_PAGE_DIVISOR   = 2'h1;
  localparam logic [1:0] UFTR_PAGE_ENHANCED  = 2'h2;

  // Field positions
  localparam int UFTR_EFR_SWFC_MSB   = 3;
  localparam int UFTR_EFR_ENH_BIT    = 4;
  localparam int UFTR_EFR_SPECIAL    = 5;
  localparam int UFTR_EFR_AUTO_RTS   = 6;
  localparam int UFTR_EFR_AUTO_CTS   = 7;
  localparam int UFTR_IER_SLEEP      = 4;
  localparam int UFTR_MCR_RDY_EN     = 2;
  localparam int UFTR_MCR_LOOPBACK   = 4;
  localparam int UFTR_MCR_LVL_ACCESS = 6;
  localparam int UFTR_IIR_SPECIAL    = 4;

  // Protected bit masks
  localparam logic [7:0] UFTR_IER_ENH_MASK = 8'hF0;
  localparam logic [7:0] UFTR_FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] UFTR_MCR_ENH_MASK = 8'hE0;

  // Reset values
  localparam logic [7:0] UFTR_RST_BYTE     = 8'h00;
  localparam logic [7:0] UFTR_RST_DIV_LOW  = 8'h01;

  // Nibble scale: each level step is four bytes
  localparam int UFTR_LEVEL_SHIFT = 2;

  // Carrier types
  typedef struct packed {
    logic [7:0] enhanced_feature_ctrl;
    logic [7:0] interrupt_enable_reg;
    logic [7:0] fifo_control_reg;
    logic [7:0] modem_control_reg;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] flow_halt_restore_levels;
    logic [7:0] fifo_trigger_levels;
  } uftr_regs_t;

  typedef struct packed {
    logic       cs_n;
    logic [1:0] page;
    logic [2:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } uftr_bus_t;

endpackage

/* hdl/uftr_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Input is asynchronous to mclk
// Notes:   Stage one feeds only stage two

`timescale 1ns/1ps

module uftr_sync
  import uftr_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Pins in, filtered level out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } uftr_sync_st_t;

  uftr_sync_st_t st_reg;
  uftr_sync_st_t st_next;

  // Level moves only where stages two and three agree
  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pin_in;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    for (int i = 0; i < W; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;

endmodule

/* tb/uftr_regs_sva.sv */
// Purpose: Port-level checks for the flow/threshold register block
// Assumes: Single clock domain, ce mostly high
// Notes:   Checks start three edges after reset release (sync delay)
`timescale 1ns/1ps
module uftr_regs_sva
  import uftr_pkg::*;
#(
  parameter int LVL_W = 7
) (
  // Clock and reset
  input wire logic             mclk,
  input wire logic             resetn,
  input wire logic             ce,
  // Host side
  input wire uftr_bus_t        bus,
  input wire logic [7:0]       rdata,
  input wire logic             rdata_valid,
  // Channel events
  input wire logic             rx_timeout,
  input wire logic             rx_char_valid,
  input wire logic [7:0]       rx_char,
  input wire logic [7:0]       xoff2_char,
  input wire logic             iir_read,
  input wire logic             cts_pin,
  // Observed outputs
  input wire logic             tx_halt,
  input wire logic             special_flag,
  input wire logic             rx_trig_rdy,
  input wire logic [3:0]       swfc_mode,
  input wire logic [15:0]      baud_divisor
);
  logic [1:0] age_reg;
  logic       live;
  logic       div_wr;
  logic       efr_wr;
  // Internal reset lags the pin by two edges, so wait it out
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) age_reg <= 2'h0;
    else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
  end
  assign live   = (age_reg == 2'h3);
  // Write strobes that may legally move config outputs
  assign div_wr = ce && !bus.cs_n && bus.wr && !bus.addr[2] &&
                  !bus.addr[1] && (bus.page == UFTR_PAGE_DIVISOR);
  assign efr_wr = ce && !bus.cs_n && bus.wr &&
                  (bus.addr == UFTR_ADDR_EFR) &&
                  (bus.page == UFTR_PAGE_ENHANCED);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn || !live);
  sequence s_rd_req;
    ce && !bus.cs_n && bus.rd;
  endsequence
  sequence s_clear;
    ce && iir_read && special_flag &&
    !(rx_char_valid && (rx_char == xoff2_char));
  endsequence
  AST_RD_ANSWER: assert property (s_rd_req |=> rdata_valid)
    else $error("read not answered next cycle");
  AST_RD_ONLY: assert property (rdata_valid && $past(ce) |->
    $past(ce && !bus.cs_n && bus.rd)) else $error("stray read valid");
  AST_RDATA_HOLD: assert property ($changed(rdata) |-> rdata_valid)
    else $error("read data moved without a read");
  AST_DIV_CHG: assert property ($changed(baud_divisor) |->
    $past(div_wr)) else $error("divisor moved without a write");
  AST_SWFC_CHG: assert property ($changed(swfc_mode) |->
    $past(efr_wr)) else $error("flow mode moved without a write");
  AST_CTS_HALT: assert property ($rose(tx_halt) |->
    $past(cts_pin, 4) && $past(cts_pin, 5))
    else $error("halt without clear to send high");
  AST_SPEC_SET: assert property ($rose(special_flag) |->
    $past(rx_char_valid && (rx_char == xoff2_char)))
    else $error("special flag without match");
  AST_SPEC_CLR: assert property (s_clear |=> !special_flag)
    else $error("special flag not cleared");
  AST_SPEC_HOLD: assert property
    (ce && special_flag && !iir_read |=> special_flag)
    else $error("special flag dropped by itself");
  AST_TIMEOUT: assert property (ce && rx_timeout |=> rx_trig_rdy)
    else $error("timeout not reported as ready");
endmodule
bind uftr_regs uftr_regs_sva #(.LVL_W(LVL_W)) u_uftr_regs_sva (
  .mclk(mclk), .resetn(resetn), .ce(ce), .bus(bus), .rdata(rdata),
  .rdata_valid(rdata_valid), .rx_timeout(rx_timeout),
  .rx_char_valid(rx_char_valid), .rx_char(rx_char),
  .xoff2_char(xoff2_char), .iir_read(iir_read), .cts_pin(cts_pin),
  .tx_halt(tx_halt), .special_flag(special_flag),
  .rx_trig_rdy(rx_trig_rdy), .swfc_mode(swfc_mode),
  .baud_divisor(baud_divisor));

/* tb/uftr_remote.sv */
// Purpose: Far-end serial equipment driving the handshake lines
// Assumes: Bench tells it when to stop the local transmitter
// Notes:   Pin moves only at falling edges, like the bench
`timescale 1ns/1ps
module uftr_remote (
  // Clock
  input wire logic mclk,
  // Handshake lines
  input wire logic rts_out,
  input wire logic stop_req,
  output logic     cts_pin,
  output logic     paused
);
  // High on clear-to-send stops the device transmitter
  always @(negedge mclk) begin
    cts_pin <= stop_req;
    paused  <= rts_out;
  end
endmodule

/* tb/uftr_regs_tb_top.sv */
// Purpose: Directed bench for the flow/threshold register block
// Assumes: Page select models the divisor and enhanced pages
// Notes:   Inputs change at falling edges only
`timescale 1ns/1ps
module uftr_regs_tb_top
  import uftr_pkg::*;
;
  localparam uftr_bus_t IDLE = '{1'b1, 2'h0, 3'h0, 1'b0, 1'b0, 8'h00};
  logic mclk = 0, resetn = 0, ce = 1, rto = 0, rcv = 0, interrupt_ident_reg = 0, stop = 0;
  logic [6:0] rxc = 0, txs = 0, frx = 0, ftx = 0;
  logic [7:0] rch = 0, x2 = 0, rdata;
  logic [2:0] otx = 0, orx = 0;
  logic rdv, cts, rts, halt, spec, txr, rxr, paused;
  logic [3:0] swfc;
  logic [15:0] div;
  uftr_bus_t bus = IDLE;
  int fail_count = 0, tests_run = 0;
  always #25 mclk = ~mclk;
  uftr_regs u_uftr_regs (.mclk(mclk), .resetn(resetn), .ce(ce), .bus(bus),
    .rdata(rdata), .rdata_valid(rdv), .rx_count(rxc), .tx_space(txs),
    .rx_timeout(rto), .rx_char_valid(rcv), .rx_char(rch), .xoff2_char(x2),
    .fcr_rx_level(frx), .fcr_tx_level(ftx), .iir_read(interrupt_ident_reg),
    .other_tx_rdy(otx), .other_rx_rdy(orx), .cts_pin(cts), .rts_out(rts),
    .tx_halt(halt), .swfc_mode(swfc), .baud_divisor(div),
    .special_flag(spec), .tx_trig_rdy(txr), .rx_trig_rdy(rxr));
  uftr_remote u_uftr_remote (.mclk(mclk), .rts_out(rts), .stop_req(stop),
    .cts_pin(cts), .paused(paused));
  task automatic chk(input logic [15:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, m);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // One-cycle write; visible once the taking edge has passed
  task automatic wr(input logic [1:0] p, input logic [2:0] a,
                    input logic [7:0] d);
    @(negedge mclk); bus = '{1'b0, p, a, 1'b1, 1'b0, d};
    @(negedge mclk); bus = IDLE;
  endtask
  task automatic rd(input logic [1:0] p, input logic [2:0] a,
                    input logic [7:0] e, input string m);
    @(negedge mclk); bus = '{1'b0, p, a, 1'b0, 1'b1, 8'h00};
    @(negedge mclk); bus = IDLE;
    chk({15'h0, rdv}, 16'h1, m);
    chk({8'h0, rdata}, {8'h0, e}, m);
  endtask
  task automatic t_efr_div;
    wr(2'h2, 3'h2, 8'h1A);
    chk({12'h0, swfc}, 16'h000A, "flow mode");
    wr(2'h1, 3'h0, 8'h34); wr(2'h1, 3'h1, 8'h12);
    chk(div, 16'h1234, "divisor");
    wr(2'h0, 3'h1, 8'h10); wr(2'h1, 3'h0, 8'h77);
    chk(div, 16'h1234, "divisor in sleep");
    wr(2'h0, 3'h1, 8'h00);
    $display("test efr_div done");
  endtask
  task automatic t_levels;
    wr(2'h0, 3'h4, 8'h00); wr(2'h0, 3'h6, 8'h13);
    wr(2'h0, 3'h4, 8'h40);
    rd(2'h0, 3'h6, 8'h00, "levels locked");
    wr(2'h0, 3'h6, 8'h13);
    rd(2'h0, 3'h6, 8'h13, "levels");
    wr(2'h2, 3'h2, 8'h5A); // Halt 12 above restore 4
    rxc = 7'd11; tick(2); chk({15'h0, rts}, 16'h0, "rts below");
    rxc = 7'd12; tick(2);
    chk({14'h0, rts, paused}, 16'h3, "rts halt");
    rxc = 7'd5; tick(2); chk({15'h0, rts}, 16'h1, "rts hold");
    rxc = 7'd4; tick(2);
    chk({14'h0, rts, paused}, 16'h0, "rts restore");
    rxc = 7'd0; wr(2'h2, 3'h2, 8'h1A);
    $display("test levels done");
  endtask
  task automatic t_trig;
    wr(2'h0, 3'h7, 8'h21); rd(2'h0, 3'h7, 8'h21, "trigger");
    txs = 7'd3; rxc = 7'd8; tick(2);
    chk({14'h0, txr, rxr}, 16'h0, "below trigger");
    txs = 7'd4; rxc = 7'd9; tick(2);
    chk({14'h0, txr, rxr}, 16'h3, "at trigger");
    rxc = 7'd0; rto = 1; tick(2); rto = 0;
    chk({15'h0, rxr}, 16'h1, "timeout");
    wr(2'h0, 3'h7, 8'h00); ftx = 7'd16; frx = 7'd16;
    txs = 7'd15; rxc = 7'd17; tick(2);
    chk({14'h0, txr, rxr}, 16'h1, "fallback");
    txs = 7'd16; rxc = 7'd0; tick(2);
    chk({14'h0, txr, rxr}, 16'h2, "fallback tx");
    $display("test trig done");
  endtask
  task automatic t_ready;
    otx = 3'b101; orx = 3'b010;
    wr(2'h0, 3'h4, 8'h44); rd(2'h0, 3'h7, 8'h4B, "ready");
    wr(2'h0, 3'h4, 8'h54); rd(2'h0, 3'h7, 8'h00, "loopback");
    rd(2'h0, 3'h3, 8'h00, "unmapped");
    wr(2'h0, 3'h4, 8'h00);
    $display("test ready done");
  endtask
  task automatic t_special;
    x2 = 8'h13; wr(2'h2, 3'h2, 8'h3A);
    rch = 8'h12; rcv = 1; tick(1); rcv = 0; tick(1);
    chk({15'h0, spec}, 16'h0, "no match");
    rch = 8'h13; rcv = 1; tick(1); rcv = 0; tick(1);
    chk({15'h0, spec}, 16'h1, "match");
    interrupt_ident_reg = 1; tick(1); interrupt_ident_reg = 0; tick(1);
    chk({15'h0, spec}, 16'h0, "flag clear");
    rcv = 1; interrupt_ident_reg = 1; tick(1); rcv = 0; interrupt_ident_reg = 0; tick(1);
    chk({15'h0, spec}, 16'h1, "set wins");
    $display("test special done");
  endtask
  task automatic t_cts;
    wr(2'h2, 3'h2, 8'h9A); stop = 1; tick(7);
    chk({15'h0, halt}, 16'h1, "cts halt");
    stop = 0; tick(7);
    chk({15'h0, halt}, 16'h0, "cts resume");
    wr(2'h2, 3'h2, 8'h1A); stop = 1; tick(7);
    chk({15'h0, halt}, 16'h0, "cts disabled");
    stop = 0; tick(7);
    $display("test cts done");
  endtask
  task automatic t_protect;
    wr(2'h2, 3'h2, 8'h0A); wr(2'h0, 3'h1, 8'h10); wr(2'h1, 3'h0, 8'h55);
    chk(div, 16'h1255, "sleep bit locked");
    wr(2'h0, 3'h4, 8'h40); wr(2'h2, 3'h2, 8'h1A); wr(2'h0, 3'h6, 8'h77);
    wr(2'h0, 3'h4, 8'h40);
    rd(2'h0, 3'h6, 8'h13, "modem bits locked");
    $display("test protect done");
  endtask
  task automatic t_ce;
    tick(1); ce = 0; wr(2'h2, 3'h2, 8'h15); tick(1);
    chk({12'h0, swfc}, 16'h000A, "frozen by enable low");
    ce = 1; wr(2'h2, 3'h2, 8'h15);
    chk({12'h0, swfc}, 16'h0005, "enable high again");
    $display("test ce done");
  endtask
  task automatic t_reset;
    resetn = 0; tick(2);
    chk(div, 16'h0001, "divisor reset");
    chk({10'h0, swfc, spec, rts}, 16'h0, "flags reset");
    resetn = 1; tick(3);
    rd(2'h2, 3'h2, 8'h00, "feature after reset");
    $display("test reset done");
  endtask
  task automatic test_done;
    $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
  initial begin
    tick(2); resetn = 1; tick(3);
    t_efr_div(); t_levels(); t_trig(); t_ready();
    t_special(); t_cts(); t_protect(); t_ce(); t_reset();
    test_done();
  end
endmodule
